// ---- src/dpsc_host.sv ----
// host controller for one port of an asynchronous dual-port sram
// runs one array or semaphore cycle per request; reads answer with a one-cycle pulse
// assumes the sram pins are wired directly; data bus resolved outside from enables
// assumes the read word stands on the data pins from one access time after select fall until the cycle ends
// assumes the opposite port is driven by its own controller, with no shared clock
`timescale 1ns/1ps
`default_nettype none
module dpsc_host (
  input wire logic clock, // 10 MHz clock
  input wire logic rstn, // sync reset, active low
  input wire logic req_valid, // request pending
  output logic req_ready, // request accepted this cycle
  input wire logic req_write, // 1 write, 0 read
  input wire logic req_flag, // 1 semaphore flag, 0 array
  input wire logic [13:0] req_addr, // word address
  input wire logic [15:0] req_wdata, // write data
  input wire logic [1:0] req_be, // byte enables, bit1 high byte
  output logic rsp_valid, // read data pulse
  output logic [15:0] rsp_rdata, // read data
  output logic [13:0] mem_addr, // sram address
  output logic chip_select_n, // array select
  output logic flag_select_n, // semaphore select
  output logic rw_strobe, // low writes
  output logic out_en_n, // output enable
  output logic low_byte_sel_n, // low byte select
  output logic high_byte_sel_n, // high byte select
  output logic [15:0] data_out, // data to sram
  output logic data_oe, // high while host drives data
  input wire logic [15:0] data_in // data pins as seen
);
  // cycle shape, in edges after the take edge:
  //   setup  selects and byte selects low; output enable low (read) or data drive on (write)
  //   act    write strobe low for the pulse count, or the read access wait runs
  //   end    strobe back high while selects and data still stand
  //   gap    everything released for the recovery count; read word captured on entry
  //   idle   req_ready high again
  // one request at a time; req_ready is low from the take edge until idle
  // ==========================================================
  // state and registers
  dpsc_pkg::dpsc_state_t state_q, state_d;
  logic [3:0] cnt_q;
  logic wr_q, flag_q;
  logic [1:0] be_q;
  logic [15:0] wdata_q;
  logic [15:0] din_s;
  // next values of the captured request, live on the take edge itself
  logic take;
  logic wr_d, flag_d;
  logic [1:0] be_d;
  logic [15:0] wdata_d;
  // high while the next cycle is one of setup, act or end
  logic cycle_on;

  // ==========================================================
  // input synchroniser on the data pins
  dpsc_sync #(.W(dpsc_pkg::DATA_W)) u_sync (
    .clock(clock),
    .rstn(rstn),
    .d(data_in),
    .q(din_s)
  );

  // ==========================================================
  // sequencing
  // requests taken only in idle
  assign req_ready = (state_q == dpsc_pkg::DPSC_IDLE);

  // next-state selection
  always_comb begin
    state_d = state_q;
    case (state_q)
      dpsc_pkg::DPSC_IDLE: begin
        if (req_valid) begin
          state_d = dpsc_pkg::DPSC_SETUP;
        end
      end
      dpsc_pkg::DPSC_SETUP: begin
        state_d = dpsc_pkg::DPSC_ACT;
      end
      dpsc_pkg::DPSC_ACT: begin
        if (cnt_q == 4'h0) begin
          state_d = dpsc_pkg::DPSC_END;
        end
      end
      dpsc_pkg::DPSC_END: begin
        state_d = dpsc_pkg::DPSC_GAP;
      end
      dpsc_pkg::DPSC_GAP: begin
        if (cnt_q == 4'h0) begin
          state_d = dpsc_pkg::DPSC_IDLE;
        end
      end
      default: begin
        state_d = dpsc_pkg::DPSC_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_q <= dpsc_pkg::DPSC_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // phase counter: pulse width in act, recovery spacing in gap
  always_ff @(posedge clock) begin
    if (!rstn) begin
      cnt_q <= 4'h0;
    end else begin
      case (state_q)
        dpsc_pkg::DPSC_SETUP: begin
          if (wr_q) begin
            cnt_q <= flag_q ? dpsc_pkg::SOP_CNT - 4'h1 : dpsc_pkg::WP_CNT - 4'h1;
          end else begin
            cnt_q <= dpsc_pkg::RD_CNT - 4'h1;
          end
        end
        dpsc_pkg::DPSC_END: begin
          cnt_q <= dpsc_pkg::GAP_CNT - 4'h1;
        end
        default: begin
          if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // request capture
  // a request is taken on an edge where it is offered while idle;
  // req_ready already says idle, so nothing else gates it
  assign take = req_ready && req_valid;

  // the pins load on the take edge too, so they read the request directly there;
  // reading only the capture registers would put the previous request on the pins
  assign wr_d = take ? req_write : wr_q;
  assign flag_d = take ? req_flag : flag_q;
  assign be_d = take ? req_be : be_q;
  assign wdata_d = take ? req_wdata : wdata_q;

  // cycle direction, kept for the counter and the read capture
  always_ff @(posedge clock) begin
    if (!rstn) begin
      wr_q <= 1'b0;
    end else begin
      wr_q <= wr_d;
    end
  end

  // array or semaphore target; fixed for the whole cycle so the
  // select pair never swaps while a cycle stands
  always_ff @(posedge clock) begin
    if (!rstn) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  // byte enables; a semaphore cycle honours them as well, so a caller
  // must enable at least one byte to reach a flag
  always_ff @(posedge clock) begin
    if (!rstn) begin
      be_q <= 2'h0;
    end else begin
      be_q <= be_d;
    end
  end

  // write word; kept after the take edge because the request
  // inputs may move on while the cycle is still running
  always_ff @(posedge clock) begin
    if (!rstn) begin
      wdata_q <= 16'h0000;
    end else begin
      wdata_q <= wdata_d;
    end
  end

  // address moves only on the take edge, while every select and the strobe are high
  always_ff @(posedge clock) begin
    if (!rstn) begin
      mem_addr <= 14'h0000;
    end else if (take) begin
      mem_addr <= req_addr;
    end
  end

  // ==========================================================
  // pin drive
  // selects and enables stand from setup through end; all idle high otherwise
  assign cycle_on = (state_d == dpsc_pkg::DPSC_SETUP) || (state_d == dpsc_pkg::DPSC_ACT)
                    || (state_d == dpsc_pkg::DPSC_END);

  // array select: low for a whole array cycle; it leads the strobe fall
  // and outlasts its rise by one cycle each
  always_ff @(posedge clock) begin
    if (!rstn) begin
      chip_select_n <= 1'b1;
    end else begin
      chip_select_n <= ~(cycle_on && !flag_d);
    end
  end

  // semaphore select: low for a whole flag cycle, never together
  // with the array select
  always_ff @(posedge clock) begin
    if (!rstn) begin
      flag_select_n <= 1'b1;
    end else begin
      flag_select_n <= ~(cycle_on && flag_d);
    end
  end

  // write strobe: low in act only, after the selects have settled; it rises one
  // cycle before the selects, and the recovery count in gap starts at the select rise
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rw_strobe <= 1'b1;
    end else begin
      rw_strobe <= ~(wr_d && state_d == dpsc_pkg::DPSC_ACT);
    end
  end

  // output enable: low only for reads, so the sram never drives during
  // a write and the plain pulse width is enough
  always_ff @(posedge clock) begin
    if (!rstn) begin
      out_en_n <= 1'b1;
    end else begin
      out_en_n <= ~(cycle_on && !wr_d);
    end
  end

  // low byte select; together with the high one it also gates
  // when the sram turns its outputs on and off
  always_ff @(posedge clock) begin
    if (!rstn) begin
      low_byte_sel_n <= 1'b1;
    end else begin
      low_byte_sel_n <= ~(cycle_on && be_d[0]);
    end
  end

  // high byte select
  always_ff @(posedge clock) begin
    if (!rstn) begin
      high_byte_sel_n <= 1'b1;
    end else begin
      high_byte_sel_n <= ~(cycle_on && be_d[1]);
    end
  end

  // ==========================================================
  // write data
  // data drive: on from setup of a write, held one cycle past the strobe rise
  always_ff @(posedge clock) begin
    if (!rstn) begin
      data_oe <= 1'b0;
    end else begin
      data_oe <= cycle_on && wr_d;
    end
  end

  // write word follows the request from the take edge, so the
  // word on the pins is the new one from setup on
  always_ff @(posedge clock) begin
    if (!rstn) begin
      data_out <= 16'h0000;
    end else begin
      data_out <= wdata_d;
    end
  end

  // ==========================================================
  // read answer
  // one-cycle pulse on leaving end; the access wait covers the input flops
  // as well, so the synchronised word is the settled pin level by then
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= (state_q == dpsc_pkg::DPSC_END) && !wr_q;
    end
  end

  // read word captured at the same edge, held until the next read
  // so a slow consumer can still pick it up
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rsp_rdata <= 16'h0000;
    end else if (state_q == dpsc_pkg::DPSC_END && !wr_q) begin
      rsp_rdata <= din_s;
    end
  end
endmodule
`default_nettype wire

// ---- src/dpsc_pkg.sv ----
// package for the dual-port sram port-cycle controller (host side)
// assumes one 10 MHz clock, synchronous active-low reset, fastest grade timing
package dpsc_pkg;
  localparam int unsigned CLK_NS = 100;
  localparam int unsigned ADDR_W = 14;
  localparam int unsigned DATA_W = 16;
  // device times in ns
  localparam int unsigned T_AOE_NS = 15;
  localparam int unsigned T_ACC_NS = 25;
  localparam int unsigned T_OH_NS = 3;
  localparam int unsigned T_EW_NS = 20;
  localparam int unsigned T_WC_NS = 25;
  localparam int unsigned T_WP_NS = 20;
  localparam int unsigned T_WZ_NS = 15;
  localparam int unsigned T_DW_NS = 15;
  localparam int unsigned T_SOP_NS = 15;
  localparam int unsigned T_SAA_NS = 35;
  localparam int unsigned T_SWRD_NS = 5;
  localparam int unsigned T_BDD_NS = 35;
  // least times round up
  localparam int unsigned WP_CYC = ((T_WZ_NS + T_DW_NS > T_WP_NS ? T_WZ_NS + T_DW_NS : T_WP_NS)
                                    + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SOP_CYC = (T_SOP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SWRD_CYC = (T_SWRD_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned WC_CYC = (T_WC_NS + CLK_NS - 1) / CLK_NS;
  // read wait covers the latest of the access and busy release delays
  localparam int unsigned RD_NS_MAX = (T_SAA_NS > T_BDD_NS) ? T_SAA_NS : T_BDD_NS;
  // the pins settle within the access time, then cross the three input flops and the
  // agreement stage, which costs two act cycles more than the access time alone
  localparam int unsigned SYNC_CYC = 2;
  localparam int unsigned RD_CYC = (RD_NS_MAX + CLK_NS - 1) / CLK_NS + SYNC_CYC;
  localparam logic [3:0] WP_CNT = 4'(WP_CYC);
  localparam logic [3:0] RD_CNT = 4'(RD_CYC);
  localparam logic [3:0] SOP_CNT = 4'(SOP_CYC);
  localparam logic [3:0] GAP_CNT = 4'(SWRD_CYC > WC_CYC ? SWRD_CYC : WC_CYC);

  typedef enum logic [2:0] {
    DPSC_IDLE = 3'h0,
    DPSC_SETUP = 3'h1,
    DPSC_ACT = 3'h3,
    DPSC_END = 3'h2,
    DPSC_GAP = 3'h6
  } dpsc_state_t;
endpackage

// ---- src/dpsc_sync.sv ----
// three-flop input synchroniser, one bit per lane
// assumes inputs asynchronous to clock
`timescale 1ns/1ps
`default_nettype none
module dpsc_sync #(
  parameter int unsigned W = 16
) (
  input wire logic clock, // system clock
  input wire logic rstn, // sync reset, active low
  input wire logic [W-1:0] d, // raw pin levels
  output logic [W-1:0] q // settled levels
);
  logic [W-1:0] s1_q, s2_q, s3_q;
  // shift chain; second and third stages feed the agreement check
  always_ff @(posedge clock) begin
    if (!rstn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // per bit, take the new level once two stages agree
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clock) begin
        if (!rstn) begin
          q[i] <= 1'b0;
        end else if (s2_q[i] == s3_q[i]) begin
          q[i] <= s3_q[i];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ---- tb/dpsc_host_chk.sv ----
// checker for the port-cycle host controller
// assumes it is bound to every dpsc_host instance
`timescale 1ns/1ps
`default_nettype none
module dpsc_host_chk (
  input wire logic clock, // clock
  input wire logic rstn, // reset
  input wire logic req_valid, // request
  input wire logic req_ready, // taken
  input wire logic req_write, // write
  input wire logic rsp_valid, // read done
  input wire logic [13:0] mem_addr, // address
  input wire logic chip_select_n, // array select
  input wire logic flag_select_n, // flag select
  input wire logic rw_strobe, // write strobe
  input wire logic out_en_n, // output enable
  input wire logic [15:0] data_out, // write data
  input wire logic data_oe // data drive
);
  // ==========================================
  // port cycle checks
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence rd_take; req_valid && req_ready && !req_write; endsequence
  sequence wr_take; req_valid && req_ready && req_write; endsequence
  sel_excl_a: assert property (chip_select_n || flag_select_n)
    else $error("both selects low");
  addr_hold_a: assert property (!$stable(mem_addr) |-> rw_strobe && $past(rw_strobe))
    else $error("address moved in write");
  strobe_ctl_a: assert property (!rw_strobe |->
    out_en_n && data_oe && !(chip_select_n && flag_select_n))
    else $error("strobe without select or data");
  no_clash_a: assert property (!out_en_n |-> !data_oe)
    else $error("host drives while reading");
  data_hold_a: assert property ($rose(rw_strobe) |-> data_oe && $stable(data_out))
    else $error("data dropped at write end");
  sel_lead_a: assert property ($fell(rw_strobe) |-> $past(!chip_select_n || !flag_select_n))
    else $error("select late for write");
  read_done_a: assert property (rd_take |-> ##[4:7] rsp_valid)
    else $error("read answer missing");
  read_wait_a: assert property (rsp_valid |-> $past(!out_en_n, 3) && $past(!out_en_n, 4))
    else $error("read sampled too early");
  write_go_a: assert property (wr_take |-> ##[2:3] !rw_strobe)
    else $error("write strobe missing");
  flag_gap_a: assert property ($rose(flag_select_n) |=> flag_select_n)
    else $error("flag reselected at once");
  write_setup_a: assert property (wr_take |=> out_en_n && data_oe)
    else $error("write setup without data drive");
  read_setup_a: assert property (rd_take |=> !out_en_n && !data_oe)
    else $error("read setup without output enable");
endmodule
bind dpsc_host dpsc_host_chk chk (.clock, .rstn, .req_valid, .req_ready, .req_write, .rsp_valid,
  .mem_addr, .chip_select_n, .flag_select_n, .rw_strobe, .out_en_n, .data_out, .data_oe);
`default_nettype wire

// ---- tb/dpsc_sram_model.sv ----
// model of one port of the dual-port sram with semaphore flags
// assumes host pins wired directly; data_in is the resolved data pin
`timescale 1ns/1ps
`default_nettype none
module dpsc_sram_model #(
  parameter int ACC_NS = 25 // read access delay
) (
  input wire logic [13:0] mem_addr, // address
  input wire logic chip_select_n, // array select
  input wire logic flag_select_n, // flag select
  input wire logic rw_strobe, // write strobe
  input wire logic out_en_n, // output enable
  input wire logic low_byte_sel_n, // low byte
  input wire logic high_byte_sel_n, // high byte
  input wire logic [15:0] data_out, // host data
  input wire logic data_oe, // host drives
  output logic [15:0] data_in // pin level
);
  logic [15:0] mem [0:16383];
  logic [7:0] flag_q = 8'hFF; // all flags free
  logic [15:0] rd_v;
  logic drv;
  // ==========================================
  // write lands at the end of the strobe and select overlap
  always @(posedge rw_strobe) begin
    if (!chip_select_n && flag_select_n) begin
      if (!low_byte_sel_n) mem[mem_addr][7:0] = data_in[7:0];
      if (!high_byte_sel_n) mem[mem_addr][15:8] = data_in[15:8];
    end else if (chip_select_n && !flag_select_n) begin
      flag_q[mem_addr[2:0]] = data_in[0];
    end
  end
  // delayed read path keeps old data a while after an address move
  assign #(ACC_NS) rd_v = flag_select_n ? mem[mem_addr]
    : {16{flag_q[mem_addr[2:0]]}};
  assign drv = !out_en_n && rw_strobe && (chip_select_n != flag_select_n)
    && !(low_byte_sel_n && high_byte_sel_n);
  // released pins show the inverse of the last word
  assign data_in = data_oe ? data_out : (drv ? rd_v : ~rd_v);
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the port-cycle host controller
// assumes package, design, model and checker compiled before it
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic w;
    logic f;
    logic [13:0] a;
    logic [15:0] d;
    logic [1:0] be;
    logic [15:0] x;
  } dpsc_row_t;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic req_flag = 1'b0;
  logic [13:0] req_addr = 14'h0000;
  logic [15:0] req_wdata = 16'h0000;
  logic [1:0] req_be = 2'h3;
  logic req_ready, rsp_valid, chip_select_n, flag_select_n, rw_strobe, out_en_n;
  logic low_byte_sel_n, high_byte_sel_n, data_oe;
  logic [13:0] mem_addr;
  logic [15:0] rsp_rdata, data_out, data_in;
  int n_fail = 0;
  int n_tests = 0;
  dpsc_row_t rows [9] = '{
    {1'b1, 1'b0, 14'h0000, 16'h1234, 2'h3, 16'h0000},
    {1'b1, 1'b0, 14'h3FFF, 16'hABCD, 2'h3, 16'h0000},
    {1'b0, 1'b0, 14'h0000, 16'h0000, 2'h3, 16'h1234},
    {1'b0, 1'b0, 14'h3FFF, 16'h0000, 2'h3, 16'hABCD},
    {1'b1, 1'b0, 14'h0000, 16'h55AA, 2'h1, 16'h0000},
    {1'b0, 1'b0, 14'h0000, 16'h0000, 2'h3, 16'h12AA},
    {1'b1, 1'b1, 14'h0002, 16'h0000, 2'h3, 16'h0000},
    {1'b0, 1'b1, 14'h0002, 16'h0000, 2'h3, 16'h0000},
    {1'b0, 1'b1, 14'h0005, 16'h0000, 2'h3, 16'hFFFF}};
  dpsc_host uut (.clock, .rstn, .req_valid, .req_ready, .req_write, .req_flag, .req_addr,
    .req_wdata, .req_be, .rsp_valid, .rsp_rdata, .mem_addr, .chip_select_n, .flag_select_n,
    .rw_strobe, .out_en_n, .low_byte_sel_n, .high_byte_sel_n, .data_out, .data_oe, .data_in);
  dpsc_sram_model #(.ACC_NS(35)) sram (.mem_addr, .chip_select_n, .flag_select_n, .rw_strobe,
    .out_en_n, .low_byte_sel_n, .high_byte_sel_n, .data_out, .data_oe, .data_in);
  // ==========================================
  // clock, compare and request helpers
  always #50 clock = ~clock;
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic do_req(input dpsc_row_t r);
    int k;
    k = 0;
    @(posedge clock);
    req_valid <= 1'b1;
    req_write <= r.w;
    req_flag <= r.f;
    req_addr <= r.a;
    req_wdata <= r.d;
    req_be <= r.be;
    @(negedge clock);
    while (req_ready !== 1'b1 && k < 50) begin
      @(negedge clock);
      k++;
    end
    check({15'h0000, req_ready}, 16'h0001);
    @(posedge clock);
    req_valid <= 1'b0;
    if (!r.w) begin
      k = 0;
      @(negedge clock);
      while (rsp_valid !== 1'b1 && k < 50) begin
        @(negedge clock);
        k++;
      end
      check({15'h0000, rsp_valid}, 16'h0001);
      check(rsp_rdata, r.x);
    end
  endtask
  task automatic report_and_stop;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================
  // main sequence: table rows, then mid-write reset
  initial begin
    repeat (9) @(posedge clock);
    @(negedge clock);
    check({11'h000, chip_select_n, flag_select_n, rw_strobe, out_en_n, data_oe}, 16'h001E);
    @(posedge clock);
    rstn <= 1'b1;
    for (int i = 0; i < 9; i++) do_req(rows[i]);
    do_req({1'b1, 1'b0, 14'h0001, 16'h0F0F, 2'h3, 16'h0000});
    @(posedge clock);
    rstn <= 1'b0;
    @(posedge clock);
    @(negedge clock);
    check({11'h000, chip_select_n, flag_select_n, rw_strobe, out_en_n, data_oe}, 16'h001E);
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    do_req(rows[5]);
    report_and_stop();
  end
  // watchdog against a hung handshake
  initial begin
    #(100 * 3000);
    n_fail++;
    report_and_stop();
  end
endmodule
`default_nettype wire
